//--- jnvm_pkg.sv
// Constants, types and carriers for the test-port nonvolatile access block
package jnvm_pkg;
    localparam int IR_W = 4;
    localparam int DR_W = 24;
    localparam int CMD_W = 8;
    localparam int ARG_W = 16;
    localparam int BYTE_W = 8;
    localparam int CMD_LSB = 16;
    localparam int CLK_PERIOD_NS = 50;
    // Test-port instruction codes
    localparam logic [IR_W-1:0] IR_PROGRAMMING_COMMAND_INSTRUCTION = 4'h4;
    localparam logic [IR_W-1:0] IR_PAGE_LOAD = 4'h6;
    localparam logic [IR_W-1:0] IR_PAGE_READ = 4'h7;
    localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    // Numbered programming instruction codes, carried in the top data byte
    localparam logic [CMD_W-1:0] CMD_FLASH_RD_EN = 8'h3a;
    localparam logic [CMD_W-1:0] CMD_FLASH_ADDR_HI = 8'h3b;
    localparam logic [CMD_W-1:0] CMD_FLASH_ADDR_LO = 8'h3c;
    localparam logic [CMD_W-1:0] CMD_FLASH_RD = 8'h3d;
    localparam logic [CMD_W-1:0] CMD_EE_WR_EN = 8'h4a;
    localparam logic [CMD_W-1:0] CMD_EE_ADDR_HI = 8'h4b;
    localparam logic [CMD_W-1:0] CMD_EE_ADDR_LO = 8'h4c;
    localparam logic [CMD_W-1:0] CMD_EE_DATA = 8'h4d;
    localparam logic [CMD_W-1:0] CMD_EE_LATCH = 8'h4e;
    localparam logic [CMD_W-1:0] CMD_EE_COMMIT = 8'h4f;
    localparam logic [CMD_W-1:0] CMD_EE_POLL = 8'h4a ^ 8'h0d;
    localparam logic [CMD_W-1:0] CMD_EE_RD_EN = 8'h5a;
    localparam logic [CMD_W-1:0] CMD_EE_RD_ADDR_HI = 8'h5b;
    localparam logic [CMD_W-1:0] CMD_EE_RD_ADDR_LO = 8'h5c;
    localparam logic [CMD_W-1:0] CMD_EE_RD = 8'h5d;
    localparam logic [CMD_W-1:0] CMD_FUSE_WR_EN = 8'h6a;
    localparam logic [CMD_W-1:0] CMD_FUSE_HI_DATA = 8'h6b;
    localparam logic [CMD_W-1:0] CMD_FUSE_HI_WR = 8'h6c;
    localparam logic [CMD_W-1:0] CMD_FUSE_HI_POLL = 8'h6d;
    localparam logic [CMD_W-1:0] CMD_FUSE_LO_DATA = 8'h6e;
    localparam logic [CMD_W-1:0] CMD_FUSE_LO_WR = 8'h6f;
    localparam logic [CMD_W-1:0] CMD_FUSE_LO_POLL = 8'h60;
    // Reset values
    localparam logic [BYTE_W-1:0] FUSE_HIGH_RST = 8'hff;
    localparam logic [BYTE_W-1:0] FUSE_LOW_RST = 8'hff;
    localparam logic [ARG_W-1:0] ARG_ZERO = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    typedef enum logic [3:0] {
        TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010,
        TAP_CAP_DR = 4'b0011, TAP_SHIFT_DR = 4'b0100, TAP_EXIT1_DR = 4'b0101,
        TAP_PAUSE_DR = 4'b0110, TAP_EXIT2_DR = 4'b0111, TAP_UPD_DR = 4'b1000,
        TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SHIFT_IR = 4'b1011,
        TAP_EXIT1_IR = 4'b1100, TAP_PAUSE_IR = 4'b1101, TAP_EXIT2_IR = 4'b1110,
        TAP_UPD_IR = 4'b1111
    } jnvm_tap_t;

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000, MODE_FLASH_RD = 3'b001, MODE_EE_WR = 3'b010,
        MODE_EE_RD = 3'b011, MODE_FUSE_WR = 3'b100
    } jnvm_mode_t;

    typedef enum logic [1:0] {
        PEND_EE = 2'b00, PEND_FUSE_HI = 2'b01, PEND_FUSE_LO = 2'b10
    } jnvm_pend_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jnvm_pins_t;

    typedef struct packed {
        logic [CMD_W-1:0] code;
        logic [ARG_W-1:0] arg;
    } jnvm_cmd_t;
endpackage

//--- jnvm_access.sv
// Test-port flash read, EEPROM and fuse access with page-stream FIFO
module jnvm_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != (AW+1)'(D));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
            count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end
endmodule

// Function
// - Programming commands only under command instruction.
// - Flash word read: enable, address, read.
// - Capture fetches data, advances counter per word.
// - Stream low byte first, to last word.
// - First shifted byte already valid data.
// - EEPROM write: enable, addresses, data, latch, commit.
// - Completion poll reports end of write.
// - EEPROM byte read: enable, address, read.
// - High fuse: enable, load, write.
// - Fuse bit zero programs, one unprograms.
// - Low fuse load refused while any write is busy.
// - Low fuse: load, write, then poll.
module jnvm_access #(
    parameter int FLASH_AW = 10,
    parameter int EE_AW = 9,
    parameter int EE_PAGE_AW = 2,
    parameter int FIFO_DEPTH = 8,
    parameter int unsigned WRITE_WAIT_NS = 4000000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Test access port
    input wire jnvm_pkg::jnvm_pins_t tap_in,
    output logic tdo,
    output logic tdo_oe,
    // Flash preload
    input wire logic flash_wr,
    input wire logic [FLASH_AW-1:0] flash_wr_addr,
    input wire logic [jnvm_pkg::ARG_W-1:0] flash_wr_data,
    // Fuse and status
    output logic [jnvm_pkg::BYTE_W-1:0] fuse_high,
    output logic [jnvm_pkg::BYTE_W-1:0] fuse_low,
    output logic nvm_busy
);
    import jnvm_pkg::*;
    localparam int unsigned WAIT_RAW = (WRITE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAIT_CYC = (WAIT_RAW < 1) ? 1 : WAIT_RAW;
    localparam int EE_PAGE = 2 ** EE_PAGE_AW;

    jnvm_pins_t s1, s2, s3;
    logic tck_lvl;
    jnvm_tap_t tap, next_tap;
    logic [IR_W-1:0] ir, ir_sh;
    logic [DR_W-1:0] dr;
    jnvm_mode_t mode;
    jnvm_pend_t pend;
    logic [ARG_W-1:0] addr, rdata;
    logic poll_last, byte_sel;
    logic [31:0] wait_cnt;
    logic [BYTE_W-1:0] ee_data, fuse_hi_data, fuse_lo_data;
    logic [EE_PAGE-1:0] dirty;
    logic [EE_AW-EE_PAGE_AW-1:0] ee_page;
    logic [FLASH_AW:0] fetch_ptr;
    logic [ARG_W-1:0] flash_mem [2**FLASH_AW];
    logic [BYTE_W-1:0] ee_mem [2**EE_AW];
    logic [BYTE_W-1:0] page_buf [EE_PAGE];
    logic fifo_in_ready, fifo_out_valid;
    logic [ARG_W-1:0] fifo_out_data;

    // Edge finding on the sampled test clock
    wire tck_rise = s2.tck && s3.tck && !tck_lvl;
    wire tck_fall = !s2.tck && !s3.tck && tck_lvl;
    wire jnvm_cmd_t cmd = dr;
    wire upd_dr = tck_rise && (tap == TAP_UPD_DR);
    wire upd_ir = tck_rise && (tap == TAP_UPD_IR);
    wire cap_dr = tck_rise && (tap == TAP_CAP_DR);
    wire exec = upd_dr && (ir == IR_PROGRAMMING_COMMAND_INSTRUCTION);
    wire in_pr = (ir == IR_PAGE_READ);
    wire pr_enter = upd_ir && (ir_sh == IR_PAGE_READ);
    wire busy = (wait_cnt != 32'h0);
    wire done = (wait_cnt == 32'h1);
    wire fetch_done = fetch_ptr[FLASH_AW];
    wire pr_pop = cap_dr && in_pr && byte_sel;
    wire [ARG_W-1:0] flash_q = flash_mem[addr[FLASH_AW-1:0]];
    wire [BYTE_W-1:0] ee_q = ee_mem[addr[EE_AW-1:0]];
    wire is_poll = (cmd.code == CMD_EE_POLL) || (cmd.code == CMD_FUSE_HI_POLL)
        || (cmd.code == CMD_FUSE_LO_POLL);
    wire [ARG_W-1:0] cap_data = poll_last ? {15'h0000, !busy} : rdata;
    wire [BYTE_W-1:0] pr_byte = byte_sel ? fifo_out_data[15:8] : fifo_out_data[7:0];
    wire md_fr = (mode == MODE_FLASH_RD);
    wire md_ew = (mode == MODE_EE_WR);
    wire md_er = (mode == MODE_EE_RD);
    wire md_fw = (mode == MODE_FUSE_WR);
    wire fuse_hi_ld = exec && md_fw && cmd.code == CMD_FUSE_HI_DATA && !busy;
    wire fuse_lo_ld = exec && md_fw && cmd.code == CMD_FUSE_LO_DATA && !busy;
    wire start_ee = exec && md_ew && cmd.code == CMD_EE_COMMIT && !busy;
    wire start_fhi = exec && md_fw && cmd.code == CMD_FUSE_HI_WR && !busy;
    wire start_flo = exec && md_fw && cmd.code == CMD_FUSE_LO_WR && !busy;
    wire addr_hi = exec && ((md_fr && cmd.code == CMD_FLASH_ADDR_HI)
        || (md_ew && cmd.code == CMD_EE_ADDR_HI) || (md_er && cmd.code == CMD_EE_RD_ADDR_HI));
    wire addr_lo = exec && ((md_fr && cmd.code == CMD_FLASH_ADDR_LO)
        || (md_ew && cmd.code == CMD_EE_ADDR_LO) || (md_er && cmd.code == CMD_EE_RD_ADDR_LO));
    wire latch_ee = exec && md_ew && cmd.code == CMD_EE_LATCH;
    wire [EE_PAGE_AW-1:0] ee_slot = addr[EE_PAGE_AW-1:0];
    assign nvm_busy = busy;

    // Three-stage sampling of the test pins
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            tck_lvl <= 1'b0;
        end
        else
        begin
            s1 <= tap_in;
            s2 <= s1;
            s3 <= s2;
            tck_lvl <= (s2.tck == s3.tck) ? s3.tck : tck_lvl;
        end
    end

    always_comb
    begin
        next_tap = tap;
        unique case (tap)
            TAP_RESET: next_tap = s3.tms ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap = s3.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = s3.tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = s3.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tap = s3.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tap = s3.tms ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tap = s3.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tap = s3.tms ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tap = s3.tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = s3.tms ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = s3.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tap = s3.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tap = s3.tms ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tap = s3.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tap = s3.tms ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tap = s3.tms ? TAP_SEL_DR : TAP_IDLE;
        endcase
    end

    // Controller state, instruction and data shifters
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tap <= TAP_RESET;
            ir <= IR_BYPASS;
            ir_sh <= IR_CAPTURE;
            dr <= '0;
        end
        else if (tck_rise)
        begin
            tap <= next_tap;
            if (tap == TAP_RESET)
                ir <= IR_BYPASS;
            else if (tap == TAP_UPD_IR)
                ir <= ir_sh;
            if (tap == TAP_CAP_IR)
                ir_sh <= IR_CAPTURE;
            else if (tap == TAP_SHIFT_IR)
                ir_sh <= {s3.tdi, ir_sh[IR_W-1:1]};
            if (tap == TAP_CAP_DR && in_pr)
                dr <= {ARG_ZERO, pr_byte};
            else if (tap == TAP_CAP_DR)
                dr <= {BYTE_ZERO, cap_data};
            else if (tap == TAP_SHIFT_DR && ir == IR_PROGRAMMING_COMMAND_INSTRUCTION)
                dr <= {s3.tdi, dr[DR_W-1:1]};
            else if (tap == TAP_SHIFT_DR && in_pr)
                dr <= {dr[DR_W-1:BYTE_W], s3.tdi, dr[BYTE_W-1:1]};
            else if (tap == TAP_SHIFT_DR)
                dr <= {dr[DR_W-1:1], s3.tdi};
        end
    end

    // Output changes on the falling test clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo <= (tap == TAP_SHIFT_IR) ? ir_sh[0] : dr[0];
            tdo_oe <= (tap == TAP_SHIFT_IR) || (tap == TAP_SHIFT_DR);
        end
    end

    // Command execution; codes are fixed constants
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mode <= MODE_NONE;
            addr <= '0;
            rdata <= '0;
            poll_last <= 1'b0;
            ee_data <= '0;
            fuse_hi_data <= FUSE_HIGH_RST;
            fuse_lo_data <= FUSE_LOW_RST;
        end
        else if (exec)
        begin
            poll_last <= is_poll;
            if (cmd.code == CMD_FLASH_RD_EN)
                mode <= MODE_FLASH_RD;
            else if (cmd.code == CMD_EE_WR_EN)
                mode <= MODE_EE_WR;
            else if (cmd.code == CMD_EE_RD_EN)
                mode <= MODE_EE_RD;
            else if (cmd.code == CMD_FUSE_WR_EN)
                mode <= MODE_FUSE_WR;
            if (addr_hi)
                addr <= {cmd.arg[7:0], addr[7:0]};
            if (addr_lo)
                addr <= {addr[15:8], cmd.arg[7:0]};
            if (md_fr && cmd.code == CMD_FLASH_RD)
                rdata <= flash_q;
            if (md_er && cmd.code == CMD_EE_RD)
                rdata <= {BYTE_ZERO, ee_q};
            if (md_ew && cmd.code == CMD_EE_DATA)
                ee_data <= cmd.arg[7:0];
            if (fuse_hi_ld)
                fuse_hi_data <= cmd.arg[7:0];
            if (fuse_lo_ld)
                fuse_lo_data <= cmd.arg[7:0];
        end
    end

    // Self-timed write and commit of EEPROM page or fuse byte
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt <= 32'h0;
            pend <= PEND_EE;
            dirty <= '0;
            ee_page <= '0;
            fuse_high <= FUSE_HIGH_RST;
            fuse_low <= FUSE_LOW_RST;
        end
        else if (start_ee || start_fhi || start_flo)
        begin
            wait_cnt <= WAIT_CYC;
            pend <= start_ee ? PEND_EE : (start_fhi ? PEND_FUSE_HI : PEND_FUSE_LO);
            ee_page <= addr[EE_AW-1:EE_PAGE_AW];
        end
        else
        begin
            wait_cnt <= busy ? wait_cnt - 32'h1 : wait_cnt;
            if (done && pend == PEND_FUSE_HI)
                fuse_high <= fuse_hi_data;
            if (done && pend == PEND_FUSE_LO)
                fuse_low <= fuse_lo_data;
            if (done && pend == PEND_EE)
                dirty <= '0;
            if (latch_ee)
                dirty[ee_slot] <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (flash_wr)
            flash_mem[flash_wr_addr] <= flash_wr_data;
        if (latch_ee && !busy)
            page_buf[ee_slot] <= ee_data;
        for (int i = 0; i < EE_PAGE; i++)
            if (done && pend == PEND_EE && dirty[i])
                ee_mem[{ee_page, EE_PAGE_AW'(i)}] <= page_buf[i];
    end

    // Page-stream producer and byte selector
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fetch_ptr <= '0;
            byte_sel <= 1'b0;
        end
        else if (pr_enter)
        begin
            fetch_ptr <= {1'b0, addr[FLASH_AW-1:0]};
            byte_sel <= 1'b0;
        end
        else
        begin
            fetch_ptr <= (in_pr && !fetch_done && fifo_in_ready) ?
                (FLASH_AW+1)'(fetch_ptr + 1'b1) : fetch_ptr;
            byte_sel <= (cap_dr && in_pr) ? !byte_sel : byte_sel;
        end
    end

    jnvm_fifo #(
        .W(ARG_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(pr_enter),
        .in_valid(in_pr && !fetch_done),
        .in_ready(fifo_in_ready),
        .in_data(flash_mem[fetch_ptr[FLASH_AW-1:0]]),
        .out_valid(fifo_out_valid),
        .out_ready(pr_pop),
        .out_data(fifo_out_data)
    );

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_cmd_only_selected: assert property (upd_dr && ir != IR_PROGRAMMING_COMMAND_INSTRUCTION |=>
        $stable(mode) && $stable(addr)) else $error("command taken outside selection");
    a_flash_word_read: assert property (exec && md_fr && cmd.code == CMD_FLASH_RD |=>
        rdata == $past(flash_q)) else $error("flash word read wrong");
    a_stream_advance: assert property (pr_pop && fifo_out_valid |=>
        !byte_sel && u_fifo.rd_ptr == $past(u_fifo.rd_ptr) + 1'b1)
        else $error("stream did not advance");
    a_stream_low_first: assert property (pr_enter |=> !byte_sel
        && fetch_ptr[FLASH_AW-1:0] == $past(addr[FLASH_AW-1:0])) else $error("stream start");
    a_first_byte_valid: assert property (cap_dr && in_pr && !fetch_done |->
        fifo_out_valid) else $error("stream byte not ready at capture");
    a_ee_commit_time: assert property (start_ee |=> busy && wait_cnt == WAIT_CYC)
        else $error("EEPROM commit did not start timer");
    a_poll_reports: assert property (cap_dr && ir == IR_PROGRAMMING_COMMAND_INSTRUCTION && poll_last |=>
        dr[0] == !$past(busy)) else $error("poll value wrong");
    a_ee_byte_read: assert property (exec && md_er && cmd.code == CMD_EE_RD |=>
        rdata[7:0] == $past(ee_q)) else $error("EEPROM read wrong");
    a_fuse_hi_write: assert property (done && pend == PEND_FUSE_HI && !start_ee
        |=> fuse_high == $past(fuse_hi_data)) else $error("high fuse not written");
    a_fuse_lo_refused: assert property (exec && cmd.code == CMD_FUSE_LO_DATA && busy
        |=> $stable(fuse_lo_data)) else $error("low fuse loaded while busy");
    a_fuse_lo_write: assert property (start_flo |=> pend == PEND_FUSE_LO && busy)
        else $error("low fuse write not started");
    c_stream_word: cover property (pr_pop ##[1:400] pr_pop);
    c_ee_commit: cover property (done && pend == PEND_EE && dirty != '0);
    c_fuse_low: cover property (done && pend == PEND_FUSE_LO);
endmodule

//--- jnvm_prog.sv
// Test-port programmer model driving the access block's pins
module jnvm_prog (
    // Clock for pacing
    input wire logic sys_clk,
    // Test access port
    output jnvm_pkg::jnvm_pins_t tap,
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    import jnvm_pkg::*;

    initial tap = '0;

    // One test clock period; test clock idles low between ticks
    task automatic tick(input logic tms, input logic tdi, output logic seen);
        @(negedge sys_clk);
        tap.tms = tms;
        tap.tdi = tdi;
        repeat (3) @(negedge sys_clk);
        seen = tdo;
        tap.tck = 1'b1;
        repeat (4) @(negedge sys_clk);
        tap.tck = 1'b0;
    endtask

    // Idle to idle scan, data in low bit first; idle data line toggles
    task automatic scan(input logic is_ir, input int n, input logic [DR_W-1:0] din,
        output logic [DR_W-1:0] dout);
        logic b;
        dout = '0;
        tick(1'b1, ~tap.tdi, b);
        if (is_ir)
        begin
            tick(1'b1, ~tap.tdi, b);
        end
        tick(1'b0, ~tap.tdi, b);
        tick(1'b0, ~tap.tdi, b);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], b);
            dout[i] = b;
        end
        tick(1'b1, ~tap.tdi, b);
        tick(1'b0, ~tap.tdi, b);
    endtask
endmodule

//--- jtag_nvm_read_and_fuse_program_tb.sv
// Self-checking bench for the test-port nonvolatile access block
module jtag_nvm_read_and_fuse_program_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import jnvm_pkg::*;
    logic sys_clk, rst, flash_wr, tdo, tdo_oe, nvm_busy;
    logic [9:0] flash_wr_addr;
    logic [ARG_W-1:0] flash_wr_data;
    logic [BYTE_W-1:0] fuse_high, fuse_low;
    logic [DR_W-1:0] got;
    jnvm_pins_t tap;
    int bad_count, comparisons, cycles;

    jnvm_access #(.WRITE_WAIT_NS(12500)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .tap_in(tap), .tdo(tdo), .tdo_oe(tdo_oe),
        .flash_wr(flash_wr), .flash_wr_addr(flash_wr_addr), .flash_wr_data(flash_wr_data),
        .fuse_high(fuse_high), .fuse_low(fuse_low), .nvm_busy(nvm_busy));
    jnvm_prog i_prog (.sys_clk(sys_clk), .tap(tap), .tdo(tdo));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 60000)
        begin
            bad_count = bad_count + 1;
            test_done();
        end
    end

    function automatic logic [15:0] fw(input int i);
        return 16'h1234 + 16'(i) * 16'h1111;
    endfunction

    task automatic check(input string what, input logic [DR_W-1:0] exp,
        input logic [DR_W-1:0] seen);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cmd(input logic [CMD_W-1:0] code, input logic [ARG_W-1:0] arg);
        i_prog.scan(1'b0, DR_W, {code, arg}, got);
    endtask

    task automatic ir(input logic [IR_W-1:0] code);
        i_prog.scan(1'b1, IR_W, {20'h0, code}, got);
    endtask

    task automatic t_reset;
        logic b;
        check("fuse_high", FUSE_HIGH_RST, fuse_high);
        check("fuse_low", FUSE_LOW_RST, fuse_low);
        check("busy/oe", 2'b00, {nvm_busy, tdo_oe});
        for (int i = 0; i < 8; i++)
        begin
            @(negedge sys_clk);
            flash_wr = 1'b1;
            flash_wr_addr = 10'(i);
            flash_wr_data = fw(i);
        end
        @(negedge sys_clk);
        flash_wr = 1'b0;
        i_prog.tick(1'b0, 1'b0, b);
        ir(IR_PROGRAMMING_COMMAND_INSTRUCTION);
        check("ir capture", 24'h1, got);
    endtask

    task automatic t_flash_word;
        cmd(CMD_FLASH_RD_EN, ARG_ZERO);
        for (int a = 5; a >= 2; a -= 3)
        begin
            cmd(CMD_FLASH_ADDR_HI, ARG_ZERO);
            cmd(CMD_FLASH_ADDR_LO, 16'(a));
            cmd(CMD_FLASH_RD, ARG_ZERO);
            cmd(CMD_FLASH_RD, ARG_ZERO);
            check("flash word", {8'h00, fw(a)}, got);
        end
    endtask

    task automatic t_page(input int base, input int nbytes);
        logic [15:0] w;
        ir(IR_PROGRAMMING_COMMAND_INSTRUCTION);
        cmd(CMD_FLASH_RD_EN, ARG_ZERO);
        cmd(CMD_FLASH_ADDR_HI, ARG_ZERO);
        cmd(CMD_FLASH_ADDR_LO, 16'(base));
        ir(IR_PAGE_READ);
        for (int k = 0; k < nbytes; k++)
        begin
            i_prog.scan(1'b0, BYTE_W, '0, got);
            w = fw(base + k / 2);
            check("stream byte", {16'h0, k[0] ? w[15:8] : w[7:0]}, got);
        end
        ir(IR_PROGRAMMING_COMMAND_INSTRUCTION);
    endtask

    task automatic t_eeprom;
        cmd(CMD_EE_WR_EN, ARG_ZERO);
        cmd(CMD_EE_ADDR_HI, ARG_ZERO);
        for (int j = 1; j < 3; j++)
        begin
            cmd(CMD_EE_ADDR_LO, 16'(j));
            cmd(CMD_EE_DATA, {8'h00, j[1] ? 8'h3c : 8'hc3});
            cmd(CMD_EE_LATCH, ARG_ZERO);
        end
        cmd(CMD_EE_COMMIT, ARG_ZERO);
        cmd(CMD_EE_POLL, ARG_ZERO);
        cmd(CMD_EE_POLL, ARG_ZERO);
        check("ee poll", 24'h1, got);
        cmd(CMD_EE_RD_EN, ARG_ZERO);
        for (int j = 1; j < 3; j++)
        begin
            cmd(CMD_EE_RD_ADDR_HI, ARG_ZERO);
            cmd(CMD_EE_RD_ADDR_LO, 16'(j));
            cmd(CMD_EE_RD, ARG_ZERO);
            cmd(CMD_EE_RD, ARG_ZERO);
            check("ee byte", {16'h0, j[1] ? 8'h3c : 8'hc3}, got);
        end
    endtask

    task automatic t_fuse;
        cmd(CMD_FUSE_WR_EN, ARG_ZERO);
        cmd(CMD_FUSE_HI_DATA, 16'h009d);
        cmd(CMD_FUSE_HI_WR, ARG_ZERO);
        check("nvm_busy", 1'b1, nvm_busy);
        cmd(CMD_FUSE_HI_POLL, ARG_ZERO);
        cmd(CMD_FUSE_HI_POLL, ARG_ZERO);
        check("fuse hi poll", 24'h1, got);
        check("fuse_high", 8'h9d, fuse_high);
        cmd(CMD_FUSE_LO_DATA, 16'h0062);
        cmd(CMD_FUSE_LO_WR, ARG_ZERO);
        cmd(CMD_FUSE_LO_DATA, 16'h0000);
        cmd(CMD_FUSE_LO_POLL, ARG_ZERO);
        cmd(CMD_FUSE_LO_POLL, ARG_ZERO);
        check("fuse lo poll", 24'h1, got);
        check("fuse_low", 8'h62, fuse_low);
    endtask

    task automatic test_done;
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        flash_wr = 1'b0;
        flash_wr_addr = '0;
        flash_wr_data = '0;
        bad_count = 0;
        comparisons = 0;
        cycles = 0;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        t_reset();
        t_flash_word();
        t_page(0, 8);
        t_page(4, 4);
        t_eeprom();
        t_fuse();
        test_done();
    end
endmodule
